// file: tlp_pkg.sv
// Purpose: Shared constants for the tagged link pacing and remote control block
// Assumes: Avalon-MM slave with 32-bit data, byte addresses
// Notes: Register offsets are byte addresses
package tlp_pkg;
  // ****************************
  // Register map
  // ****************************
  localparam logic [7:0] TLP_REG_CTRL = 8'h00;
  localparam logic [7:0] TLP_REG_LINK_STAT = 8'h04;
  localparam logic [7:0] TLP_REG_PACE_CMD = 8'h08;
  localparam logic [7:0] TLP_REG_MANUAL = 8'h0c;
  localparam logic [7:0] TLP_REG_COUNTS = 8'h10;
  // ****************************
  // Fields
  // ****************************
  localparam int TLP_CTRL_REMOTE_CAP = 0;
  localparam int TLP_CTRL_START_REMOTE = 1;
  localparam int TLP_PACE_LINK_LSB = 0;
  localparam int TLP_PACE_START = 8;
  localparam int TLP_MAN_BLANKED = 2;
  localparam logic [31:0] TLP_CTRL_RESET = 32'h0000_0001;
  localparam logic [31:0] TLP_UNMAPPED_DATA = 32'h0000_0000;
  // ****************************
  // Link command codes
  // ****************************
  typedef enum logic [2:0] {
    TLP_CMD_NONE = 3'h0,
    TLP_CMD_XMIT_ON = 3'h1,
    TLP_CMD_XMIT_OFF = 3'h2,
    TLP_CMD_NULL = 3'h3,
    TLP_CMD_LINK_REMOTE = 3'h4,
    TLP_CMD_LINK_LOCAL = 3'h5,
    TLP_CMD_RET_LOCAL = 3'h6
  } tlp_cmd_t;
  typedef enum logic [1:0] {
    TLP_SEND_IDLE,
    TLP_SEND_OFF,
    TLP_SEND_NULL1,
    TLP_SEND_NULL2
  } tlp_send_t;
endpackage

// file: tlp_ctrl.sv
// Purpose: Per-link pacing and remote/local handling for tagged links
// Assumes: Command packets arrive already decoded, one per cycle at most
// Notes: Bus slave answers reads and writes in one wait cycle
//
// The address map and register access over Avalon-MM were decided locally.
`timescale 1ns/10ps
module tlp_ctrl #(
  parameter int LINKS = 4,
  parameter int LW = 2
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Link state from the link machines
  input wire logic [LINKS-1:0] link_active,
  input wire logic [LINKS-1:0] link_tagged,
  // Received commands
  input wire logic rx_cmd_valid,
  input wire logic [2:0] rx_cmd,
  input wire logic [LW-1:0] rx_cmd_link,
  // Received data packet offer and acceptance
  input wire logic rx_pkt_valid,
  input wire logic [LW-1:0] rx_pkt_link,
  output logic rx_pkt_accept,
  // Outgoing data gate
  output logic [LINKS-1:0] tx_out_enable,
  // Pacing command sender
  output logic tx_cmd_valid,
  output logic [2:0] tx_cmd,
  output logic [LW-1:0] tx_cmd_link,
  input wire logic tx_cmd_done,
  // Remote/local
  input wire logic gpib_remote,
  output logic gpib_rtl_pulse,
  output logic manual_enable,
  output logic menu_show
);
  // ****************************
  // State
  // ****************************
  logic [LINKS-1:0] out_en;
  logic [LINKS-1:0] off_pending;
  logic [LINKS-1:0] one_taken;
  logic [LINKS-1:0] link_remote;
  logic [LINKS-1:0] peer_enabled;
  logic [LINKS-1:0] active_q;
  logic [LINKS-1:0] pace_ok;
  logic [31:0] ctrl;
  logic menu_blanked;
  logic [15:0] ack_count;
  tlp_pkg::tlp_send_t send_state;
  logic [LW-1:0] send_link;
  logic start_req;
  logic [LW-1:0] start_link;
  logic bus_busy;
  logic any_inhibit;
  logic [LINKS-1:0] est;
  tlp_pkg::tlp_cmd_t cmd;

  function automatic logic [LINKS-1:0] link_bit(input logic [LW-1:0] idx);
    link_bit = '0;
    link_bit[idx] = 1'b1;
  endfunction

  assign cmd = tlp_pkg::tlp_cmd_t'(rx_cmd);
  assign pace_ok = link_active & link_tagged;
  assign est = link_active & ~active_q;
  assign any_inhibit = gpib_remote | (|(link_remote & link_active));

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      active_q <= '0;
    end else if (clk_en) begin
      active_q <= link_active;
    end
  end

  // ****************************
  // Responder side of pacing
  // ****************************
  // OFF acts at once on the gate: no wait for the peer to take anything
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      out_en <= '0;
      off_pending <= '0;
    end else if (clk_en) begin
      for (int i = 0; i < LINKS; i++) begin
        if (!link_active[i]) begin
          out_en[i] <= 1'b0;
          off_pending[i] <= 1'b0;
        end else if (est[i]) begin
          out_en[i] <= link_tagged[i];
          off_pending[i] <= 1'b0;
        end else if (rx_cmd_valid && rx_cmd_link == LW'(i) && pace_ok[i]) begin
          if (cmd == tlp_pkg::TLP_CMD_XMIT_ON) begin
            out_en[i] <= 1'b1;
            off_pending[i] <= 1'b0;
          end else if (cmd == tlp_pkg::TLP_CMD_XMIT_OFF) begin
            out_en[i] <= 1'b0;
            off_pending[i] <= 1'b1;
          end
        end else begin
          off_pending[i] <= 1'b0;
        end
      end
    end
  end

  // At most one packet taken in the window before the gate closes
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      one_taken <= '0;
      rx_pkt_accept <= 1'b0;
    end else if (clk_en) begin
      rx_pkt_accept <= 1'b0;
      if (rx_pkt_valid && link_active[rx_pkt_link]) begin
        if (!(off_pending[rx_pkt_link] && one_taken[rx_pkt_link])) begin
          rx_pkt_accept <= 1'b1;
        end
      end
      for (int i = 0; i < LINKS; i++) begin
        if (!off_pending[i]) begin
          one_taken[i] <= 1'b0;
        end else if (rx_pkt_valid && rx_pkt_link == LW'(i)) begin
          one_taken[i] <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_out_enable <= '0;
    end else if (clk_en) begin
      tx_out_enable <= out_en & pace_ok;
    end
  end

  // ****************************
  // Sender side of pacing
  // ****************************
  // Both roles live here since either end may throttle
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      send_state <= tlp_pkg::TLP_SEND_IDLE;
      send_link <= '0;
      tx_cmd_valid <= 1'b0;
      tx_cmd <= tlp_pkg::TLP_CMD_NONE;
      tx_cmd_link <= '0;
      ack_count <= '0;
    end else if (clk_en) begin
      case (send_state)
        tlp_pkg::TLP_SEND_IDLE: begin
          if (start_req && pace_ok[start_link]) begin
            send_state <= tlp_pkg::TLP_SEND_OFF;
            send_link <= start_link;
            tx_cmd_valid <= 1'b1;
            tx_cmd <= tlp_pkg::TLP_CMD_XMIT_OFF;
            tx_cmd_link <= start_link;
          end
        end
        tlp_pkg::TLP_SEND_OFF: begin
          if (tx_cmd_done) begin
            send_state <= tlp_pkg::TLP_SEND_NULL1;
            tx_cmd <= tlp_pkg::TLP_CMD_NULL;
          end
        end
        tlp_pkg::TLP_SEND_NULL1: begin
          if (tx_cmd_done) begin
            send_state <= tlp_pkg::TLP_SEND_NULL2;
          end
        end
        tlp_pkg::TLP_SEND_NULL2: begin
          if (tx_cmd_done) begin
            send_state <= tlp_pkg::TLP_SEND_IDLE;
            tx_cmd_valid <= 1'b0;
            tx_cmd <= tlp_pkg::TLP_CMD_NONE;
            ack_count <= ack_count + 16'h0001;
          end
        end
        default: begin
          send_state <= tlp_pkg::TLP_SEND_IDLE;
          tx_cmd_valid <= 1'b0;
        end
      endcase
      if (!link_active[send_link] && send_state != tlp_pkg::TLP_SEND_IDLE) begin
        send_state <= tlp_pkg::TLP_SEND_IDLE;
        tx_cmd_valid <= 1'b0;
        tx_cmd <= tlp_pkg::TLP_CMD_NONE;
      end
    end
  end

  // Peer counted enabled until the second NULL goes out
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      peer_enabled <= '0;
    end else if (clk_en) begin
      for (int i = 0; i < LINKS; i++) begin
        if (!link_active[i]) begin
          peer_enabled[i] <= 1'b0;
        end else if (est[i]) begin
          peer_enabled[i] <= link_tagged[i];
        end else if (send_state == tlp_pkg::TLP_SEND_NULL2 && tx_cmd_done
                     && send_link == LW'(i)) begin
          peer_enabled[i] <= 1'b0;
        end
      end
    end
  end

  // ****************************
  // Remote and local
  // ****************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      link_remote <= '0;
    end else if (clk_en) begin
      for (int i = 0; i < LINKS; i++) begin
        if (!link_active[i]) begin
          link_remote[i] <= 1'b0;
        end else if (est[i]) begin
          // Local start unless capability is off and software asks otherwise
          link_remote[i] <= !ctrl[tlp_pkg::TLP_CTRL_REMOTE_CAP]
                            && ctrl[tlp_pkg::TLP_CTRL_START_REMOTE];
        end else if (rx_cmd_valid && rx_cmd_link == LW'(i)
                     && ctrl[tlp_pkg::TLP_CTRL_REMOTE_CAP]) begin
          if (cmd == tlp_pkg::TLP_CMD_LINK_REMOTE) begin
            link_remote[i] <= 1'b1;
          end else if (cmd == tlp_pkg::TLP_CMD_LINK_LOCAL) begin
            link_remote[i] <= 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      gpib_rtl_pulse <= 1'b0;
    end else if (clk_en) begin
      // Link remote flags are deliberately untouched here
      gpib_rtl_pulse <= rx_cmd_valid && cmd == tlp_pkg::TLP_CMD_RET_LOCAL;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      manual_enable <= 1'b1;
      menu_show <= 1'b1;
      menu_blanked <= 1'b0;
    end else if (clk_en) begin
      manual_enable <= !any_inhibit;
      if (any_inhibit) begin
        menu_show <= 1'b0;
        menu_blanked <= menu_blanked | menu_show;
      end else begin
        menu_show <= 1'b1;
        menu_blanked <= 1'b0;
      end
    end
  end

  // ****************************
  // Avalon-MM slave
  // ****************************
  // One wait cycle keeps read data registered
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_busy <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= '0;
      ctrl <= tlp_pkg::TLP_CTRL_RESET;
      start_req <= 1'b0;
      start_link <= '0;
    end else if (clk_en) begin
      // A request for a link that cannot pace is dropped, not kept for later
      if (send_state != tlp_pkg::TLP_SEND_IDLE || !pace_ok[start_link]) begin
        start_req <= 1'b0;
      end
      if ((avs_read || avs_write) && !bus_busy) begin
        bus_busy <= 1'b1;
        avs_waitrequest <= 1'b0;
        avs_readdata <= tlp_pkg::TLP_UNMAPPED_DATA;
        if (avs_write) begin
          case (avs_address)
            tlp_pkg::TLP_REG_CTRL: ctrl <= {30'h0, avs_writedata[1:0]};
            tlp_pkg::TLP_REG_PACE_CMD: begin
              if (avs_writedata[tlp_pkg::TLP_PACE_START]) begin
                start_req <= 1'b1;
                start_link <= avs_writedata[LW-1:0];
              end
            end
            default: ;
          endcase
        end else begin
          case (avs_address)
            tlp_pkg::TLP_REG_CTRL: avs_readdata <= ctrl;
            tlp_pkg::TLP_REG_LINK_STAT: avs_readdata <= 32'({link_remote, peer_enabled, out_en});
            tlp_pkg::TLP_REG_PACE_CMD: avs_readdata <= 32'({send_state, start_req});
            tlp_pkg::TLP_REG_MANUAL: avs_readdata <= {29'h0, menu_blanked, menu_show, manual_enable};
            tlp_pkg::TLP_REG_COUNTS: avs_readdata <= {16'h0, ack_count};
            default: ;
          endcase
        end
      end else begin
        bus_busy <= 1'b0;
        avs_waitrequest <= 1'b1;
      end
    end
  end
endmodule // tlp_ctrl

// file: tlp_chk.sv
// Purpose: Port checker for the tagged link pacing block
// Assumes: One clock, asynchronous active-low reset, clk_en held high
// Notes: Bound to every tlp_ctrl instance
`timescale 1ns/10ps
module tlp_chk #(
  parameter int LINKS = 4,
  parameter int LW = 2
) (
  // Clock and reset
  input logic sys_clk,
  input logic reset_n,
  // Links and commands
  input logic [LINKS-1:0] link_active,
  input logic [LINKS-1:0] link_tagged,
  input logic rx_cmd_valid,
  input logic [2:0] rx_cmd,
  input logic [LW-1:0] rx_cmd_link,
  input logic rx_pkt_valid,
  input logic [LW-1:0] rx_pkt_link,
  input logic rx_pkt_accept,
  input logic [LINKS-1:0] tx_out_enable,
  input logic tx_cmd_valid,
  input logic [2:0] tx_cmd,
  input logic tx_cmd_done,
  // Remote/local
  input logic gpib_remote,
  input logic gpib_rtl_pulse,
  input logic manual_enable,
  input logic menu_show
);
  // ****************************
  // Properties
  // ****************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic pace_ok;
  // Pacing only counts on a live tagged link
  assign pace_ok = rx_cmd_valid && link_tagged[rx_cmd_link] && link_active[rx_cmd_link];
  off_stop_a: assert property (pace_ok && rx_cmd == 3'h2
    |-> ##2 !tx_out_enable[$past(rx_cmd_link, 2)]) else $error("output on after off");
  on_start_a: assert property (pace_ok && rx_cmd == 3'h1
    |-> ##2 tx_out_enable[$past(rx_cmd_link, 2)]) else $error("output off after on");
  close_clear_a: assert property ($fell(link_active[0])
    |-> ##[1:2] !tx_out_enable[0]) else $error("enable kept on closed link");
  accept_live_a: assert property (rx_pkt_accept
    |-> $past(rx_pkt_valid) && $past(link_active[rx_pkt_link])) else $error("bad accept");
  rtl_pulse_a: assert property (rx_cmd_valid && rx_cmd == 3'h6
    |=> gpib_rtl_pulse ##1 !gpib_rtl_pulse) else $error("no return to local pulse");
  gpib_inhibit_a: assert property (gpib_remote [*3]
    |-> !manual_enable) else $error("manual on in bus remote");
  menu_back_a: assert property (manual_enable |-> menu_show)
    else $error("menu hidden while manual on");
  cmd_hold_a: assert property (tx_cmd_valid && !tx_cmd_done
    |=> tx_cmd_valid && $stable(tx_cmd)) else $error("command dropped early");
  off_first_a: assert property ($rose(tx_cmd_valid)
    |-> tx_cmd == 3'h2) else $error("halt not opened by off");
  cover property (tx_cmd_done && tx_cmd == 3'h3);
  cover property (pace_ok && rx_cmd == 3'h2);
  cover property (rx_pkt_accept);
endmodule // tlp_chk

bind tlp_ctrl tlp_chk #(.LINKS(LINKS), .LW(LW)) u_chk (.sys_clk(sys_clk), .reset_n(reset_n),
  .link_active(link_active), .link_tagged(link_tagged), .rx_cmd_valid(rx_cmd_valid),
  .rx_cmd(rx_cmd), .rx_cmd_link(rx_cmd_link), .rx_pkt_valid(rx_pkt_valid),
  .rx_pkt_link(rx_pkt_link), .rx_pkt_accept(rx_pkt_accept), .tx_out_enable(tx_out_enable),
  .tx_cmd_valid(tx_cmd_valid), .tx_cmd(tx_cmd), .tx_cmd_done(tx_cmd_done),
  .gpib_remote(gpib_remote), .gpib_rtl_pulse(gpib_rtl_pulse),
  .manual_enable(manual_enable), .menu_show(menu_show));

// file: tlp_peer.sv
// Purpose: Peer module answering pacing commands on the link
// Assumes: Commands held until done, as the sender contract says
// Notes: dly sets how slowly each command is accepted
`timescale 1ns/10ps
module tlp_peer (
  // Clock and reset
  input logic sys_clk,
  input logic reset_n,
  // Command link
  input logic tx_cmd_valid,
  input logic [2:0] tx_cmd,
  input logic [3:0] dly,
  output logic tx_cmd_done,
  // Observation
  output logic [8:0] log_cmds,
  output logic [3:0] n_cmds
);
  // ****************************
  // Acceptance
  // ****************************
  logic [3:0] cnt;
  // Skips the done cycle so one command is never taken twice
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_cmd_done <= 1'b0;
      cnt <= 4'h0;
      log_cmds <= 9'h000;
      n_cmds <= 4'h0;
    end else begin
      tx_cmd_done <= 1'b0;
      if (tx_cmd_valid && !tx_cmd_done && cnt == dly) begin
        tx_cmd_done <= 1'b1;
        cnt <= 4'h0;
        log_cmds <= {log_cmds[5:0], tx_cmd};
        n_cmds <= n_cmds + 4'h1;
      end else if (tx_cmd_valid && !tx_cmd_done) begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule // tlp_peer

// file: tagged_link_pacing_remote_ctrl_tb.sv
// Purpose: Self-checking bench for the tagged link pacing block
// Assumes: Avalon-MM answer in one wait cycle, clk_en held high
// Notes: Links 0..2 tagged, link 3 not
`timescale 1ns/10ps
module tagged_link_pacing_remote_ctrl_tb;
  logic sys_clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, gpib_remote = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0, avs_write = 1'b0, rx_cmd_valid = 1'b0, rx_pkt_valid = 1'b0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [3:0] link_active = 4'h0, link_tagged = 4'h7, tx_out_enable, dly = 4'h3, n_cmds;
  logic [2:0] rx_cmd = 3'h0, tx_cmd;
  logic [1:0] rx_cmd_link = 2'h0, rx_pkt_link = 2'h0, tx_cmd_link;
  logic avs_waitrequest, rx_pkt_accept, tx_cmd_valid, tx_cmd_done;
  logic gpib_rtl_pulse, manual_enable, menu_show;
  logic [8:0] log_cmds;
  int fail_count = 0, check_count = 0;
  always #4 sys_clk = ~sys_clk;
  tlp_ctrl #(.LINKS(4), .LW(2)) uut (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .link_active(link_active), .link_tagged(link_tagged),
    .rx_cmd_valid(rx_cmd_valid), .rx_cmd(rx_cmd), .rx_cmd_link(rx_cmd_link),
    .rx_pkt_valid(rx_pkt_valid), .rx_pkt_link(rx_pkt_link), .rx_pkt_accept(rx_pkt_accept),
    .tx_out_enable(tx_out_enable), .tx_cmd_valid(tx_cmd_valid), .tx_cmd(tx_cmd),
    .tx_cmd_link(tx_cmd_link), .tx_cmd_done(tx_cmd_done), .gpib_remote(gpib_remote),
    .gpib_rtl_pulse(gpib_rtl_pulse), .manual_enable(manual_enable), .menu_show(menu_show));
  tlp_peer peer (.sys_clk(sys_clk), .reset_n(reset_n), .tx_cmd_valid(tx_cmd_valid),
    .tx_cmd(tx_cmd), .dly(dly), .tx_cmd_done(tx_cmd_done), .log_cmds(log_cmds),
    .n_cmds(n_cmds));
  // ****************************
  // Shared tasks
  // ****************************
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  // Holds the request until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= d;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic cmd(input logic [2:0] c, input logic [1:0] l);
    @(posedge sys_clk);
    rx_cmd_valid <= 1'b1;
    rx_cmd <= c;
    rx_cmd_link <= l;
    @(posedge sys_clk);
    rx_cmd_valid <= 1'b0;
    tick(3);
  endtask
  task automatic links(input logic [3:0] v);
    @(posedge sys_clk);
    link_active <= v;
    tick(3);
  endtask
  task automatic pkt(input logic [1:0] l, input logic exp);
    @(posedge sys_clk);
    rx_pkt_valid <= 1'b1;
    rx_pkt_link <= l;
    @(posedge sys_clk);
    rx_pkt_valid <= 1'b0;
    @(negedge sys_clk);
    chk("accept", 32'(rx_pkt_accept), 32'(exp));
  endtask
  // ****************************
  // Scenarios
  // ****************************
  task automatic t_regs();
    bus(1'b0, tlp_pkg::TLP_REG_CTRL, 32'h0);
    chk("ctrl", q, tlp_pkg::TLP_CTRL_RESET);
    bus(1'b0, 8'h20, 32'h0);
    chk("unmapped", q, tlp_pkg::TLP_UNMAPPED_DATA);
    bus(1'b0, tlp_pkg::TLP_REG_MANUAL, 32'h0);
    chk("manual reg", q & 32'h3, 32'h3);
    $display("regs done");
  endtask
  task automatic t_pace();
    links(4'h3);
    chk("enable", 32'(tx_out_enable), 32'h3);
    cmd(3'h2, 2'h0);
    chk("enable", 32'(tx_out_enable), 32'h2);
    cmd(3'h2, 2'h0);
    chk("enable", 32'(tx_out_enable), 32'h2);
    pkt(2'h0, 1'b1);
    cmd(3'h1, 2'h0);
    chk("enable", 32'(tx_out_enable), 32'h3);
    cmd(3'h1, 2'h0);
    chk("enable", 32'(tx_out_enable), 32'h3);
    cmd(3'h1, 2'h2);
    chk("enable", 32'(tx_out_enable), 32'h3);
    pkt(2'h2, 1'b0);
    $display("pace done");
  endtask
  task automatic t_send();
    for (int i = 1; i <= 2; i++) begin
      dly <= (i == 1) ? 4'h3 : 4'h0;
      bus(1'b1, tlp_pkg::TLP_REG_PACE_CMD, 32'h0000_0101);
      for (int t = 0; t < 100 && n_cmds != 4'(3 * i); t++) tick(0);
      tick(2);
      chk("sent", 32'(log_cmds), 32'h0000_009b);
      chk("cmd link", 32'(tx_cmd_link), 32'h1);
      chk("sending", 32'(tx_cmd_valid), 32'h0);
      bus(1'b0, tlp_pkg::TLP_REG_COUNTS, 32'h0);
      chk("acks", q, 32'(i));
      bus(1'b0, tlp_pkg::TLP_REG_LINK_STAT, 32'h0);
      chk("link stat", q, 32'h0000_0013);
    end
    links(4'hb);
    cmd(3'h1, 2'h3);
    chk("enable", 32'(tx_out_enable), 32'h3);
    bus(1'b1, tlp_pkg::TLP_REG_PACE_CMD, 32'h0000_0103);
    tick(8);
    chk("sending", 32'(tx_cmd_valid), 32'h0);
    chk("sent", 32'(n_cmds), 32'h6);
    links(4'h3);
    $display("send done");
  endtask
  task automatic t_remote();
    cmd(3'h4, 2'h0);
    chk("manual", 32'(manual_enable), 32'h0);
    @(posedge sys_clk);
    rx_cmd_valid <= 1'b1;
    rx_cmd <= 3'h6;
    @(posedge sys_clk);
    rx_cmd_valid <= 1'b0;
    @(negedge sys_clk);
    chk("rtl pulse", 32'(gpib_rtl_pulse), 32'h1);
    tick(1);
    chk("rtl pulse", 32'(gpib_rtl_pulse), 32'h0);
    chk("manual", 32'(manual_enable), 32'h0);
    cmd(3'h5, 2'h0);
    chk("manual", 32'(manual_enable), 32'h1);
    chk("menu", 32'(menu_show), 32'h1);
    @(posedge sys_clk);
    gpib_remote <= 1'b1;
    tick(3);
    chk("manual", 32'(manual_enable), 32'h0);
    chk("menu", 32'(menu_show), 32'h0);
    @(posedge sys_clk);
    gpib_remote <= 1'b0;
    tick(3);
    chk("manual", 32'(manual_enable), 32'h1);
    bus(1'b1, tlp_pkg::TLP_REG_CTRL, 32'h0);
    cmd(3'h4, 2'h0);
    chk("manual", 32'(manual_enable), 32'h1);
    bus(1'b1, tlp_pkg::TLP_REG_CTRL, 32'h1);
    $display("remote done");
  endtask
  task automatic t_close();
    cmd(3'h4, 2'h0);
    links(4'h2);
    chk("enable", 32'(tx_out_enable), 32'h2);
    chk("manual", 32'(manual_enable), 32'h1);
    links(4'h3);
    chk("enable", 32'(tx_out_enable), 32'h3);
    chk("manual", 32'(manual_enable), 32'h1);
    $display("close done");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    tick(1);
    t_regs();
    t_pace();
    t_send();
    t_remote();
    t_close();
    finish_test();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    finish_test();
  end
endmodule // tagged_link_pacing_remote_ctrl_tb
